//--- hw/pts_defs.svh
`ifndef PTS_DEFS_SVH
`define PTS_DEFS_SVH
`define PTS_CLK_PERIOD_NS 32'h0000_0008
`define PTS_NS_PER_SEC 32'h3B9A_CA00
`define PTS_ADDR_CTRL 8'h00
`define PTS_ADDR_ADJ 8'h04
`define PTS_ADDR_INSCNT 8'h08
`define PTS_ADDR_RESCNT 8'h0C
`define PTS_CTRL_RST 1'b1
`define PTS_BEAT_LIMIT 6'h20
`define PTS_TS_V2_BYTES 5'h0A
`define PTS_TS_V1_BYTES 5'h08
`define PTS_CF_BYTES 5'h02
`define PTS_RES_BYTES 5'h08
`endif

//--- hw/pts_one_step_insert.sv
// The register offsets and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`include "pts_defs.svh"

// Notes on behaviour
// RL1: Ingress time input is the time the packet entered the system.
// RL2: Client gives valid ingress time at each start with residence update.
// RL3: Client holds all per-packet controls steady while start-of-packet is high.
// RL4: Ingress time is used only when residence update is requested.
// RL5: The 64-bit ingress time counts only when the 64-bit option is built.
// RL6: Timestamp format select: 0 means 96-bit V2, 1 means 64-bit V1.
// RL7: V1 time sits in bits 79 to 16 of the 96-bit time.
// RL8: Client requests insertion only when the 96-bit option is built.
// RL9: Residence format select: 0 means 96-bit time, 1 means 64-bit time.
// RL10: 64-bit residence time maps unchanged into bits 79 to 16.
// RL11: Client never picks 96-bit residence format without the 96-bit option.
// RL12: Insertion overwrites bytes starting at the given timestamp offset.
// RL13: V2 writes ten bytes at timestamp offset, two at correction offset.
// RL14: Client picks offsets so the whole timestamp lies inside the packet.
// RL15: In long packets the timestamp lies within the first 256 bytes.
// RL16: Timestamp bytes overlap no other field, the UDP checksum included.
// RL17: Insertion writes the time the packet appears on the link.
// RL18: Residence update adds transit latency to the field's contents.
// RL19: In V2 insertion the correction offset places timestamp bits 15 to 0.
// RL20: Controls are sampled at start-of-packet and apply to that packet only.
module pts_one_step_insert #(
  parameter bit TOD64_EN = 1'b1,
  parameter bit TOD96_EN = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Client transmit stream
  input wire logic inValid,
  input wire logic inSop,
  input wire logic inEop,
  input wire logic [2:0] inEmpty,
  input wire logic [63:0] inData,
  // Per-packet controls
  input wire logic ctlTsInsert,
  input wire logic ctlResUpdate,
  input wire logic ctlTsFormat,
  input wire logic ctlResFormat,
  input wire logic [15:0] ctlOffsetTs,
  input wire logic [15:0] ctlOffsetCf,
  input wire logic [63:0] ingressTime64,
  input wire logic [95:0] ingressTime96,
  // Time of day
  input wire logic [95:0] todTx96,
  input wire logic [63:0] todTx64,
  // Link stream
  output logic outValid,
  output logic outSop,
  output logic outEop,
  output logic [2:0] outEmpty,
  output logic [63:0] outData
);
  pts_pkg::pts_state_s st_q;
  pts_pkg::pts_state_s st_d;
  pts_pkg::pts_ctl_s inCtl;
  pts_pkg::pts_beat_s b2;
  pts_pkg::pts_ctl_s ctl2;
  logic [95:0] linkTs96;
  logic [95:0] tsUse;
  logic [31:0] resNsW;
  logic [191:0] win;
  logic [191:0] winSh;
  logic [191:0] edW;
  logic [63:0] resSum;
  logic [79:0] insVec;
  logic [4:0] insLen;
  logic [2:0] relTs;
  logic [2:0] relCf;
  logic matchTs;
  logic matchCf;
  logic doIns;
  logic doRes;
  logic doCf;

  pts_time_math #(.TOD64_EN(TOD64_EN)) u_math (
    .tod96(todTx96),
    .tod64(todTx64),
    .ingressTime96(ingressTime96),
    .ingressTime64(ingressTime64),
    .resFmt(ctlResFormat),
    .addNs(`PTS_CLK_PERIOD_NS + st_q.adjNs),
    .linkTs96(linkTs96),
    .resNs(resNsW)
  );

  // Edits happen on a three-beat window so a field may straddle beats.
  assign b2 = st_q.stg[2];
  assign ctl2 = st_q.ctl[2];
  assign win = {st_q.stg[2].data, st_q.stg[1].data, st_q.stg[0].data};
  assign tsUse = b2.sop ? linkTs96 : st_q.tsHeld; // [RL17]
  assign relTs = ctl2.offTs[2:0];
  assign relCf = ctl2.offCf[2:0];
  assign matchTs = b2.valid && !b2.beat[5] && (ctl2.offTs[15:3] == {7'h00, b2.beat}); // [RL15]
  assign matchCf = b2.valid && !b2.beat[5] && (ctl2.offCf[15:3] == {7'h00, b2.beat}); // [RL15]
  assign doIns = st_q.enable && TOD96_EN && ctl2.ins && matchTs; // [RL8]
  assign doRes = st_q.enable && ctl2.res && matchTs;
  assign doCf = st_q.enable && TOD96_EN && ctl2.ins && !ctl2.tsFmt && matchCf; // [RL19]
  assign insVec = ctl2.tsFmt ? {tsUse[79:16], 16'h0000} : tsUse[95:16]; // [RL6] [RL7]
  assign insLen = ctl2.tsFmt ? `PTS_TS_V1_BYTES : `PTS_TS_V2_BYTES; // [RL6]
  assign winSh = win << {relTs, 3'b000};
  assign resSum = winSh[191:128] + {16'h0000, ctl2.resNs, 16'h0000}; // [RL18]

  generate
    for (genvar i = 0; i < 24; i++) begin : g_byte
      logic [4:0] kT;
      logic [4:0] kC;
      logic [79:0] insSh;
      logic [63:0] resSh;
      assign kT = 5'(i) - {2'b00, relTs};
      assign kC = 5'(i) - {2'b00, relCf};
      assign insSh = insVec << {kT, 3'b000};
      assign resSh = resSum << {kT, 3'b000};
      // Overlapping fields are the client's fault; later terms lose. [RL16]
      assign edW[191-8*i -: 8] =
          (doCf && kC < `PTS_CF_BYTES) ? (kC[0] ? tsUse[7:0] : tsUse[15:8]) : // [RL13]
          (doIns && kT < insLen) ? insSh[79:72] : // [RL12]
          (doRes && kT < `PTS_RES_BYTES) ? resSh[63:56] : // [RL18]
          win[191-8*i -: 8];
    end
  endgenerate

  always_comb begin
    st_d = st_q;
    inCtl = st_q.held;
    if (inValid && inSop) begin // [RL20] [RL2] [RL3]
      inCtl.ins = ctlTsInsert;
      inCtl.res = ctlResUpdate;
      inCtl.tsFmt = ctlTsFormat;
      inCtl.offTs = ctlOffsetTs;
      inCtl.offCf = ctlOffsetCf;
      inCtl.resNs = ctlResUpdate ? resNsW : 32'h0000_0000; // [RL4]
      st_d.held = inCtl;
    end
    st_d.ctl[0] = inCtl;
    st_d.ctl[1] = st_q.ctl[0];
    st_d.ctl[2] = st_q.ctl[1];
    st_d.stg[0].data = inData;
    st_d.stg[0].valid = inValid;
    st_d.stg[0].sop = inValid && inSop;
    st_d.stg[0].eop = inValid && inEop;
    st_d.stg[0].empty = inEmpty;
    st_d.stg[0].beat = inSop ? 6'h00 : st_q.beatCnt;
    // Beats of one packet must be contiguous, or the window loses its field. [RL14]
    st_d.stg[1] = st_q.stg[0];
    st_d.stg[1].data = edW[63:0];
    st_d.stg[2] = st_q.stg[1];
    st_d.stg[2].data = edW[127:64];
    st_d.out = st_q.stg[2];
    st_d.out.data = edW[191:128];
    if (inValid) begin
      if (inEop) begin
        st_d.beatCnt = 6'h00;
      end else if (st_d.stg[0].beat != `PTS_BEAT_LIMIT) begin
        st_d.beatCnt = st_d.stg[0].beat + 6'h01;
      end
    end
    if (b2.valid && b2.sop) begin
      st_d.tsHeld = linkTs96; // [RL17]
      if (st_q.enable) begin
        st_d.insCnt = st_q.insCnt + {31'h0000_0000, ctl2.ins};
        st_d.resCnt = st_q.resCnt + {31'h0000_0000, ctl2.res};
      end
    end
    st_d.pready = psel && !penable;
    if (psel && !penable) begin
      st_d.prdata = 32'h0000_0000;
      st_d.pslverr = 1'b0;
      if (paddr == `PTS_ADDR_CTRL) begin
        st_d.prdata = {31'h0000_0000, st_q.enable};
      end else if (paddr == `PTS_ADDR_ADJ) begin
        st_d.prdata = st_q.adjNs;
      end else if (paddr == `PTS_ADDR_INSCNT) begin
        st_d.prdata = st_q.insCnt;
        st_d.pslverr = pwrite;
      end else if (paddr == `PTS_ADDR_RESCNT) begin
        st_d.prdata = st_q.resCnt;
        st_d.pslverr = pwrite;
      end else begin
        st_d.pslverr = 1'b1;
      end
    end
    if (psel && penable && st_q.pready && pwrite && !st_q.pslverr) begin
      if (paddr == `PTS_ADDR_CTRL) begin
        st_d.enable = pwdata[0];
      end else if (paddr == `PTS_ADDR_ADJ) begin
        st_d.adjNs = pwdata;
      end
    end
    if (srst) begin
      st_d = '0;
      st_d.enable = `PTS_CTRL_RST;
    end
  end

  always_ff @(posedge sys_clk) begin
    st_q <= st_d;
  end

  assign prdata = st_q.prdata;
  assign pready = st_q.pready;
  assign pslverr = st_q.pslverr;
  assign outValid = st_q.out.valid;
  assign outSop = st_q.out.sop;
  assign outEop = st_q.out.eop;
  assign outEmpty = st_q.out.empty;
  assign outData = st_q.out.data;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);

  a_sop_travel: assert property ( // [RL20]
    inValid && inSop |=> ##2 st_q.ctl[2].offTs == $past(ctlOffsetTs, 3))
    else $error("Offset not carried with its packet.");
  a_plain_pass: assert property ( // [RL4]
    b2.valid && !ctl2.ins && !ctl2.res |=> outData == $past(b2.data))
    else $error("Beat changed without a request.");
  a_v1_insert: assert property ( // [RL7]
    doIns && relTs == 3'h0 && ctl2.tsFmt |=> outData == $past(tsUse[79:16]))
    else $error("V1 timestamp wrong.");
  a_v1_offset: assert property ( // [RL12]
    doIns && relTs == 3'h5 && ctl2.tsFmt |=> outData[23:0] == $past(tsUse[79:56]))
    else $error("Timestamp not at its offset.");
  a_v2_insert: assert property ( // [RL13]
    doIns && relTs == 3'h0 && !ctl2.tsFmt && !doCf |=> outData == $past(tsUse[95:32])
      ##1 outData[63:48] == $past(tsUse[31:16], 2))
    else $error("V2 timestamp bytes wrong.");
  a_v2_corr: assert property ( // [RL19]
    doCf && relCf == 3'h2 |=> outData[47:32] == $past(tsUse[15:0]))
    else $error("Correction bytes wrong.");
  a_res_add: assert property ( // [RL18]
    doRes && !doIns && relTs == 3'h0 |=>
      outData == $past(b2.data) + {16'h0000, $past(ctl2.resNs), 16'h0000})
    else $error("Residence not added.");
  a_res_fmt64: assert property ( // [RL10]
    TOD64_EN && inValid && inSop && ctlResUpdate && ctlResFormat &&
      todTx64[31:0] >= ingressTime64[31:0] |=>
      st_q.ctl[0].resNs == $past(todTx64[31:0]) - $past(ingressTime64[31:0]))
    else $error("64-bit residence wrong.");
  a_res_fmt96: assert property ( // [RL9]
    inValid && inSop && ctlResUpdate && !ctlResFormat &&
      todTx96[47:16] >= ingressTime96[47:16] |=>
      st_q.ctl[0].resNs == $past(todTx96[47:16]) - $past(ingressTime96[47:16]))
    else $error("96-bit residence wrong.");
  a_link_time: assert property ( // [RL17]
    b2.valid && b2.sop && todTx96[47:16] < 32'h0100_0000 && st_q.adjNs < 32'h0100_0000 |=>
      st_q.tsHeld[47:16] == $past(todTx96[47:16]) + `PTS_CLK_PERIOD_NS + $past(st_q.adjNs))
    else $error("Link time wrong.");
  a_apb_ready: assert property (
    psel && !penable |=> pready ##1 !pready)
    else $error("APB ready not one cycle.");

  c_ins_v2: cover property (doIns && !ctl2.tsFmt);
  c_ins_v1: cover property (doIns && ctl2.tsFmt);
  c_res: cover property (doRes);
  c_apb_wr: cover property (psel && penable && pwrite && pready);
endmodule

//--- hw/pts_pkg.sv
package pts_pkg;
  typedef struct packed {
    logic [63:0] data;
    logic valid;
    logic sop;
    logic eop;
    logic [2:0] empty;
    logic [5:0] beat;
  } pts_beat_s;

  typedef struct packed {
    logic ins;
    logic res;
    logic tsFmt;
    logic [15:0] offTs;
    logic [15:0] offCf;
    logic [31:0] resNs;
  } pts_ctl_s;

  typedef struct packed {
    pts_beat_s [2:0] stg;
    pts_ctl_s [2:0] ctl;
    pts_ctl_s held;
    pts_beat_s out;
    logic [95:0] tsHeld;
    logic [5:0] beatCnt;
    logic enable;
    logic [31:0] adjNs;
    logic [31:0] insCnt;
    logic [31:0] resCnt;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pts_state_s;
endpackage

//--- hw/pts_time_math.sv
`timescale 1ns/1ps
`include "pts_defs.svh"

module pts_time_math #(
  parameter bit TOD64_EN = 1'b1
) (
  // Time of day and ingress time
  input wire logic [95:0] tod96,
  input wire logic [63:0] tod64,
  input wire logic [95:0] ingressTime96,
  input wire logic [63:0] ingressTime64,
  // Selects and link-time addend
  input wire logic resFmt,
  input wire logic [31:0] addNs,
  // Results
  output logic [95:0] linkTs96,
  output logic [31:0] resNs
);
  logic [63:0] t64;
  logic [63:0] i64;
  logic [95:0] nowV;
  logic [95:0] ingV;
  logic [31:0] nsNow;
  logic [31:0] nsIng;
  logic [32:0] sum;

  assign t64 = TOD64_EN ? tod64 : 64'h0000_0000_0000_0000; // [RL5]
  assign i64 = TOD64_EN ? ingressTime64 : 64'h0000_0000_0000_0000; // [RL5]
  assign nowV = resFmt ? {16'h0000, t64, 16'h0000} : tod96; // [RL9] [RL10]
  assign ingV = resFmt ? {16'h0000, i64, 16'h0000} : ingressTime96; // [RL9] [RL10]
  assign nsNow = nowV[47:16];
  assign nsIng = ingV[47:16];
  // Residence is assumed below one second, so only one rollover is repaired.
  assign resNs = (nsNow >= nsIng) ? nsNow - nsIng : nsNow + `PTS_NS_PER_SEC - nsIng; // [RL1]
  assign sum = {1'b0, tod96[47:16]} + {1'b0, addNs};
  assign linkTs96 = (sum >= {1'b0, `PTS_NS_PER_SEC}) ?
      {tod96[95:48] + 48'h0000_0000_0001, 32'(sum - {1'b0, `PTS_NS_PER_SEC}), tod96[15:0]} :
      {tod96[95:48], sum[31:0], tod96[15:0]};
endmodule

//--- testbench/ptp_one_step_tx_timestamp_insert_tb_top.sv
`timescale 1ns/1ps
module ptp_one_step_tx_timestamp_insert_tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [31:0] pwdata = '0, prdata;
  logic inValid = 1'b0, inSop = 1'b0, inEop = 1'b0, outValid, outSop, outEop;
  logic [2:0] inEmpty = 3'h0, outEmpty;
  logic [63:0] inData = '0, outData, ingressTime64 = '0, todTx64;
  logic ctlTsInsert = 1'b0, ctlResUpdate = 1'b0, ctlTsFormat = 1'b0, ctlResFormat = 1'b0;
  logic [15:0] ctlOffsetTs = '0, ctlOffsetCf = '0;
  logic [95:0] ingressTime96 = '0, todTx96;
  int mismatches = 0, checks = 0, seed = 91, insN = 0, resN = 0;
  logic en = 1'b1;
  logic [31:0] adj = 32'h3B9A_C9F6;
  logic [7:0] pkt[80], exb[80];
  int cs[8][7] = '{'{0, 0, 0, 0, 0, 0, 1}, '{1, 0, 0, 0, 0, 10, 3},
    '{1, 0, 0, 0, 22, 34, 6}, '{1, 0, 0, 0, 20, 2, 5}, '{1, 0, 1, 0, 5, 0, 3},
    '{0, 1, 0, 0, 8, 0, 3}, '{0, 1, 0, 1, 13, 0, 4}, '{1, 0, 1, 0, 16, 0, 4}};
  initial forever #4 sys_clk = ~sys_clk;
  pts_tod_model tod (.sys_clk, .todTx96, .todTx64);
  pts_one_step_insert uut (.sys_clk, .srst, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .inValid, .inSop, .inEop, .inEmpty, .inData, .ctlTsInsert,
    .ctlResUpdate, .ctlTsFormat, .ctlResFormat, .ctlOffsetTs, .ctlOffsetCf, .ingressTime64,
    .ingressTime96, .todTx96, .todTx64, .outValid, .outSop, .outEop, .outEmpty, .outData);
  task automatic check(input logic [63:0] seen, input logic [63:0] e);
    checks++;
    if (seen !== e) begin
      mismatches++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic apbChk(input logic wr, input logic [7:0] a, input logic [31:0] d, e,
      input logic eErr);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      mismatches++;
      conclude();
    end
    if (!wr) check(prdata, e);
    check(pslverr, eErr);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [63:0] word(input logic [7:0] b[80], input int i);
    for (int j = 0; j < 8; j++) word[63 - 8 * j -: 8] = b[8 * i + j];
  endfunction
  // Case fields: insert, residence, ts format, res format, ts offset, cf offset, beats.
  task automatic sendPkt(input int c[7]);
    logic [95:0] t0, tt;
    logic [63:0] t64, f;
    logic [2:0] emp;
    longint ns, d, inNs;
    int nb;
    nb = c[6];
    emp = 3'($random(seed));
    inNs = {$random(seed)} % 1000000000;
    for (int p = 0; p < 80; p++) begin
      pkt[p] = 8'($random(seed));
      exb[p] = pkt[p];
    end
    for (int k = 0; k < nb + 4; k++) begin
      @(posedge sys_clk);
      inValid <= k < nb;
      inSop <= k == 0;
      inEop <= k == nb - 1;
      inEmpty <= (k == nb - 1) ? emp : 3'h0;
      inData <= word(pkt, k);
      // After the start beat the controls turn to noise; only the start beat may count.
      {ctlTsInsert, ctlResUpdate, ctlTsFormat, ctlResFormat} <= (k == 0) ?
        {c[0][0], c[1][0], c[2][0], c[3][0]} : 4'($random(seed));
      ctlOffsetTs <= (k == 0) ? 16'(c[4]) : 16'($random(seed));
      ctlOffsetCf <= (k == 0) ? 16'(c[5]) : 16'($random(seed));
      ingressTime96 <= {48'($random(seed)), (k == 0) ? 32'(inNs) : 32'($random(seed)),
        16'($random(seed))};
      ingressTime64 <= {32'($random(seed)), (k == 0) ? 32'(inNs) : 32'($random(seed))};
      #1;
      if (k == 0) begin
        t0 = todTx96;
        t64 = todTx64;
      end
      if (k == 3 && en && c[0] == 1) begin
        ns = todTx96[47:16] + 8 + adj;
        tt = {todTx96[95:48] + 48'(ns >= 1000000000), 32'(ns % 1000000000), todTx96[15:0]};
        for (int j = 0; j < 10 - 2 * c[2]; j++) exb[c[4] + j] = tt[95 - 16 * c[2] - 8 * j -: 8];
        for (int j = 0; j < 2 - 2 * c[2]; j++) exb[c[5] + j] = tt[15 - 8 * j -: 8];
        insN++;
      end else if (k == 3 && en && c[1] == 1) begin
        d = longint'(c[3] ? t64[31:0] : t0[47:16]) - inNs;
        if (d < 0) d += 1000000000;
        for (int j = 0; j < 8; j++) f[63 - 8 * j -: 8] = exb[c[4] + j];
        f += {d[31:0], 16'h0000};
        for (int j = 0; j < 8; j++) exb[c[4] + j] = f[63 - 8 * j -: 8];
        resN++;
      end
      if (k >= 4) begin
        check(outData, word(exb, k - 4));
        check({outValid, outSop, outEop, outEmpty},
          {1'b1, k == 4, k == nb + 3, (k == nb + 3) ? emp : 3'h0});
      end
    end
    $display("packet test done, checks %0d", checks);
  endtask
  initial begin
    repeat (20) @(posedge sys_clk);
    srst <= 1'b0;
    apbChk(1'b0, 8'h00, '0, 32'h0000_0001, 1'b0);
    apbChk(1'b0, 8'h04, '0, 32'h0000_0000, 1'b0);
    apbChk(1'b0, 8'h08, '0, 32'h0000_0000, 1'b0);
    apbChk(1'b0, 8'h0C, '0, 32'h0000_0000, 1'b0);
    apbChk(1'b0, 8'h10, '0, 32'h0000_0000, 1'b1);
    apbChk(1'b1, 8'h08, 32'h0000_0055, '0, 1'b1);
    // A large adjustment forces the nanosecond rollover on every insertion.
    apbChk(1'b1, 8'h04, adj, '0, 1'b0);
    apbChk(1'b0, 8'h04, '0, adj, 1'b0);
    $display("register test done, checks %0d", checks);
    for (int i = 0; i < 8; i++) sendPkt(cs[i]);
    apbChk(1'b1, 8'h00, 32'h0000_0000, '0, 1'b0);
    en = 1'b0;
    sendPkt(cs[1]);
    sendPkt(cs[5]);
    apbChk(1'b1, 8'h00, 32'h0000_0001, '0, 1'b0);
    en = 1'b1;
    // A small adjustment leaves the link time without a nanosecond rollover.
    adj = 32'h0000_0010;
    apbChk(1'b1, 8'h04, adj, '0, 1'b0);
    sendPkt(cs[1]);
    apbChk(1'b0, 8'h08, '0, 32'(insN), 1'b0);
    apbChk(1'b0, 8'h0C, '0, 32'(resN), 1'b0);
    conclude();
  end
endmodule

//--- testbench/pts_tod_model.sv
`timescale 1ns/1ps
// Time source. It runs through reset, as a real time source would.
module pts_tod_model (
  // Clock
  input wire logic sys_clk,
  // Time of day
  output logic [95:0] todTx96,
  output logic [63:0] todTx64
);
  logic [47:0] sec_q = 48'h0000_0000_0005;
  logic [31:0] ns_q = 32'h3B9A_C000;
  logic [15:0] frac_q = 16'h0000;
  always_ff @(posedge sys_clk) begin
    frac_q <= frac_q + 16'h1357;
    if (ns_q + 32'h0000_0008 >= 32'h3B9A_CA00) begin
      ns_q <= ns_q + 32'h0000_0008 - 32'h3B9A_CA00;
      sec_q <= sec_q + 48'h0000_0000_0001;
    end else begin
      ns_q <= ns_q + 32'h0000_0008;
    end
  end
  assign todTx96 = {sec_q, ns_q, frac_q};
  assign todTx64 = {sec_q[31:0], ns_q};
endmodule
